// ==== hdl/ccd_seq_ctl.sv ====
// Sequencing controller for an 18-bit CCD converter with a correlated
// double sampler: drives reference hold, conversion trigger and the
// bandwidth select pins, and captures results. Assumes the converter's
// data pins are asynchronous and software runs it over APB.
//
// Summary of operation
// - Bandwidth select pins pick 800, 1000, 1333 or 2000 ns periods.
// - Conversions never start closer than 800 ns apart.
// - Reference acquires 380, 490, 630 or 680 ns before hold rises.
// - Pixel settles 350, 440, 630 or 680 ns before the trigger.
// - Hold high freezes the reference level; hold low tracks again.
// - Hold rises only after the reference has settled.
// - Conversion starts at trigger rising edge, raised after settling.
// - After the trigger, hold may fall to acquire the next reference.
// - Hold falls during the reference quiet period.
// - No input toggles 150 to 300 ns after the trigger edge; bandwidth pins still follow a rate written while idle.
// - Extended range widens that window to 140 to 320 ns.
// - After more than 1 ms between conversions, discard the next result.
//
// The placing of the registers and the APB register port are this design's own decisions.
`default_nettype none
module ccd_seq_ctl
  import ccd_ctl_pkg::*;
#(
  parameter int DATA_W    = 18,
  parameter int STALE_LIM = STALE_CYC
) (
  input  wire logic              clk_in,        // System clock, 100 MHz
  input  wire logic              rst_n_in,      // Sync reset, active low
  input  wire logic              psel_in,       // APB select
  input  wire logic              penable_in,    // APB enable
  input  wire logic              pwrite_in,     // APB direction
  input  wire logic [ADDR_W-1:0] paddr_in,      // APB byte address
  input  wire logic [31:0]       pwdata_in,     // APB write data
  output logic      [31:0]       prdata_out,    // APB read data
  output logic                   pready_out,    // APB ready
  output logic                   pslverr_out,   // APB error
  output logic                   ref_hold_out,  // Reference hold pin
  output logic                   start_conv_out, // Conversion trigger pin
  output logic                   bw_select_bit0_out, // Bandwidth bit 0
  output logic                   bw_select_bit1_out, // Bandwidth bit 1
  input  wire logic [DATA_W-1:0] data_pins_in,  // Result pins
  input  wire logic              dvalid_in      // Data-valid strobe pin
);

  // ---------------------------------------------------------------
  // Rate decoding
  // ---------------------------------------------------------------
  function automatic logic [TMR_W-1:0] period_cyc(input rate_t r);
    case (r)
      RATE_1M25: period_cyc = TMR_W'(CONV_PERIOD_CYC_0);
      RATE_1M0:  period_cyc = TMR_W'(CONV_PERIOD_CYC_1);
      RATE_750K: period_cyc = TMR_W'(CONV_PERIOD_CYC_2);
      default:   period_cyc = TMR_W'(CONV_PERIOD_CYC_3);
    endcase
  endfunction

  function automatic logic [TMR_W-1:0] acq_cyc(input rate_t r);
    case (r)
      RATE_1M25: acq_cyc = TMR_W'(REF_ACQ_CYC_0);
      RATE_1M0:  acq_cyc = TMR_W'(REF_ACQ_CYC_1);
      RATE_750K: acq_cyc = TMR_W'(REF_ACQ_CYC_2);
      default:   acq_cyc = TMR_W'(REF_ACQ_CYC_3);
    endcase
  endfunction

  function automatic logic [TMR_W-1:0] settle_cyc(input rate_t r);
    case (r)
      RATE_1M25: settle_cyc = TMR_W'(PIX_SETTLE_CYC_0);
      RATE_1M0:  settle_cyc = TMR_W'(PIX_SETTLE_CYC_1);
      RATE_750K: settle_cyc = TMR_W'(PIX_SETTLE_CYC_2);
      default:   settle_cyc = TMR_W'(PIX_SETTLE_CYC_3);
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Register file and capture
  // ---------------------------------------------------------------
  logic              run_en;
  logic [1:0]        rate_req;
  logic [DATA_W-1:0] result;
  logic              sample;
  logic              busy;
  logic              discard_pend_q;

  wire keep_res = sample & ~discard_pend_q;
  wire drop_res = sample & discard_pend_q;

  ccd_apb_regs #(
    .DATA_W (DATA_W)
  ) u_regs (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .psel_in       (psel_in),
    .penable_in    (penable_in),
    .pwrite_in     (pwrite_in),
    .paddr_in      (paddr_in),
    .pwdata_in     (pwdata_in),
    .prdata_out    (prdata_out),
    .pready_out    (pready_out),
    .pslverr_out   (pslverr_out),
    .run_en_out    (run_en),
    .rate_out      (rate_req),
    .busy_in       (busy),
    .result_in     (result),
    .result_set_in (keep_res),
    .discard_in    (drop_res)
  );

  // Codes arrive as straight binary and are kept unchanged
  ccd_capture #(
    .DATA_W (DATA_W)
  ) u_cap (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .data_pins_in (data_pins_in),
    .dvalid_in    (dvalid_in),
    .result_out   (result),
    .sample_out   (sample)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Hold falls 100 ns after the trigger edge, before the critical window
  // opens, and rises again only after the acquisition time, past it.
  // That keeps hold and trigger quiet through both temperature windows; the bandwidth pins follow the requested rate whenever idle.
  seq_state_t        state_q, state_d;
  logic [TMR_W-1:0]  tmr_q, tmr_d;
  logic [TMR_W-1:0]  since_q;
  logic [STALE_W-1:0] gap_q;
  logic              hold_q, hold_d, start_q, start_d;
  rate_t             bw_q, bw_d;

  wire   tmr_done  = (tmr_q == '0);
  wire   period_ok = (since_q >= period_cyc(bw_q) - TMR_W'(1));
  wire   stale     = (gap_q >= STALE_W'(STALE_LIM));
  wire   fire      = (state_q == S_SETTLE) & tmr_done & period_ok;
  wire   go_on     = run_en & (rate_t'(rate_req) == bw_q);

  assign busy               = (state_q != S_IDLE);
  assign ref_hold_out       = hold_q;
  assign start_conv_out     = start_q;
  assign bw_select_bit0_out = bw_q[0];
  assign bw_select_bit1_out = bw_q[1];

  always_comb begin
    state_d = state_q;
    tmr_d   = tmr_done ? tmr_q : tmr_q - TMR_W'(1);
    hold_d  = hold_q;
    start_d = start_q;
    bw_d    = bw_q;
    case (state_q)
      S_IDLE: begin
        bw_d = rate_t'(rate_req);
        if (run_en && (rate_t'(rate_req) == bw_q)) begin
          state_d = S_ACQ;
          tmr_d   = acq_cyc(bw_q) - TMR_W'(1);
        end
      end
      S_ACQ: if (tmr_done) begin
        hold_d  = 1'b1;
        state_d = S_SETTLE;
        tmr_d   = settle_cyc(bw_q) - TMR_W'(1);
      end
      S_SETTLE: if (fire) begin
        start_d = 1'b1;
        state_d = S_TRIG;
        tmr_d   = TMR_W'(TRIG_PULSE_CYC - 1);
      end
      S_TRIG: if (tmr_done) begin
        start_d = 1'b0;
        state_d = S_POST;
        tmr_d   = TMR_W'(HOLD_RELEASE_CYC - TRIG_PULSE_CYC - 1);
      end
      S_POST: if (tmr_done) begin
        hold_d  = 1'b0;
        state_d = go_on ? S_ACQ : S_IDLE;
        tmr_d   = acq_cyc(bw_q) - TMR_W'(1);
      end
      default: begin
        state_d = S_IDLE;
        hold_d  = 1'b0;
        start_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= S_IDLE;
      tmr_q   <= '0;
      hold_q  <= 1'b0;
      start_q <= 1'b0;
      bw_q    <= RATE_1M25;
    end else begin
      state_q <= state_d;
      tmr_q   <= tmr_d;
      hold_q  <= hold_d;
      start_q <= start_d;
      bw_q    <= bw_d;
    end
  end

  // ---------------------------------------------------------------
  // Spacing and staleness tracking
  // ---------------------------------------------------------------
  // Both counters saturate, so reset reads as a long idle gap and the
  // first result after power-up is dropped.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      since_q        <= '1;
      gap_q          <= STALE_W'(STALE_LIM);
      discard_pend_q <= 1'b0;
    end else begin
      if (fire) since_q <= '0;
      else if (since_q != '1) since_q <= since_q + TMR_W'(1);
      if (fire) gap_q <= '0;
      else if (!stale) gap_q <= gap_q + STALE_W'(1);
      if (fire && stale) discard_pend_q <= 1'b1;
      else if (sample) discard_pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [TMR_W-1:0] low_cnt_q, high_cnt_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      low_cnt_q  <= '1;
      high_cnt_q <= '0;
    end else begin
      if (hold_q) low_cnt_q <= '0;
      else if (low_cnt_q != '1) low_cnt_q <= low_cnt_q + TMR_W'(1);
      if (!hold_q) high_cnt_q <= '0;
      else if (high_cnt_q != '1) high_cnt_q <= high_cnt_q + TMR_W'(1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence pins_quiet_s;
    $stable(hold_q) && $stable(start_q) && $stable(bw_q);
  endsequence

  sequence trig_pulse_s;
    start_q [*5] ##1 !start_q;
  endsequence

  trig_width_a: assert property (
    $rose(start_q) |-> trig_pulse_s)
    else $error("trigger pulse is not 50 ns wide");

  hold_trig_a: assert property (
    $rose(start_q) |-> hold_q [*5] ##1 hold_q [*5] ##1 !hold_q)
    else $error("hold not released 100 ns after trigger");

  quiet_win_a: assert property (
    $rose(start_q) |-> ##14 pins_quiet_s [*8] ##1 pins_quiet_s [*8]
      ##1 pins_quiet_s [*3])
    else $error("pin toggled inside the critical window");

  conv_space_a: assert property (
    $rose(start_q) |-> $past(since_q) >= period_cyc(bw_q) - TMR_W'(1))
    else $error("conversions closer than the period");

  ref_acq_a: assert property (
    $rose(hold_q) |-> low_cnt_q >= acq_cyc(bw_q))
    else $error("reference acquisition too short");

  pix_settle_a: assert property (
    $rose(start_q) |-> high_cnt_q >= settle_cyc(bw_q))
    else $error("pixel settling too short");

  bw_hold_a: assert property (
    (state_q != S_IDLE) |=> $stable(bw_q))
    else $error("bandwidth select changed mid sequence");

  stale_drop_a: assert property (
    (fire && stale) |=> discard_pend_q && $rose(start_q))
    else $error("stale conversion not marked for discard");

endmodule
`default_nettype wire

// ==== hdl/ccd_ctl_pkg.sv ====
// Constants shared by the CCD converter sequencing controller.
// Assumes a single 100 MHz clock feeding every design module.
`default_nettype none
package ccd_ctl_pkg;

  // ---------------------------------------------------------------
  // Clock and time conversion
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;

  // Least times round up to whole cycles
  function automatic int cyc_up(input int ns);
    cyc_up = (ns * CLK_MHZ + 999) / 1000;
  endfunction

  // ---------------------------------------------------------------
  // Conversion timing per rate selection, in ns
  // ---------------------------------------------------------------
  localparam int CONV_PERIOD_NS_0 = 800;
  localparam int CONV_PERIOD_NS_1 = 1000;
  localparam int CONV_PERIOD_NS_2 = 1333;
  localparam int CONV_PERIOD_NS_3 = 2000;
  localparam int REF_ACQ_NS_0     = 380;
  localparam int REF_ACQ_NS_1     = 490;
  localparam int REF_ACQ_NS_2     = 630;
  localparam int REF_ACQ_NS_3     = 680;
  localparam int PIX_SETTLE_NS_0  = 350;
  localparam int PIX_SETTLE_NS_1  = 440;
  localparam int PIX_SETTLE_NS_2  = 630;
  localparam int PIX_SETTLE_NS_3  = 680;
  localparam int TRIG_PULSE_NS    = 50;
  localparam int HOLD_RELEASE_NS  = 100;
  localparam int DATA_SETUP_NS    = 20;
  localparam int STALE_NS         = 1000000;

  localparam int CONV_PERIOD_CYC_0 = cyc_up(CONV_PERIOD_NS_0);
  localparam int CONV_PERIOD_CYC_1 = cyc_up(CONV_PERIOD_NS_1);
  localparam int CONV_PERIOD_CYC_2 = cyc_up(CONV_PERIOD_NS_2);
  localparam int CONV_PERIOD_CYC_3 = cyc_up(CONV_PERIOD_NS_3);
  localparam int REF_ACQ_CYC_0     = cyc_up(REF_ACQ_NS_0);
  localparam int REF_ACQ_CYC_1     = cyc_up(REF_ACQ_NS_1);
  localparam int REF_ACQ_CYC_2     = cyc_up(REF_ACQ_NS_2);
  localparam int REF_ACQ_CYC_3     = cyc_up(REF_ACQ_NS_3);
  localparam int PIX_SETTLE_CYC_0  = cyc_up(PIX_SETTLE_NS_0);
  localparam int PIX_SETTLE_CYC_1  = cyc_up(PIX_SETTLE_NS_1);
  localparam int PIX_SETTLE_CYC_2  = cyc_up(PIX_SETTLE_NS_2);
  localparam int PIX_SETTLE_CYC_3  = cyc_up(PIX_SETTLE_NS_3);
  localparam int TRIG_PULSE_CYC    = cyc_up(TRIG_PULSE_NS);
  localparam int HOLD_RELEASE_CYC  = cyc_up(HOLD_RELEASE_NS);
  localparam int DATA_SETUP_CYC    = cyc_up(DATA_SETUP_NS);
  localparam int STALE_CYC         = cyc_up(STALE_NS);

  localparam int TMR_W   = 8;
  localparam int STALE_W = 17;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int         ADDR_W        = 8;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_DATA      = 8'h08;
  localparam logic [7:0] REG_COUNT     = 8'h0c;
  localparam int         CTRL_EN_BIT   = 0;
  localparam int         CTRL_RATE_LSB = 1;
  localparam int         STAT_BUSY_BIT = 0;
  localparam int         STAT_VAL_BIT  = 1;
  localparam int         STAT_OVR_BIT  = 2;
  localparam logic [2:0] CTRL_RESET    = 3'h0;

  typedef enum logic [1:0] {
    RATE_1M25 = 2'b00,
    RATE_1M0  = 2'b01,
    RATE_750K = 2'b10,
    RATE_500K = 2'b11
  } rate_t;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_ACQ    = 3'b001,
    S_SETTLE = 3'b010,
    S_TRIG   = 3'b011,
    S_POST   = 3'b100
  } seq_state_t;

endpackage
`default_nettype wire

// ==== hdl/ccd_capture.sv ====
// Result capture from the converter's parallel data pins.
// Assumes the pins are asynchronous to clk_in and the data lines stay
// valid from shortly after the strobe's fall until the next conversion.
`default_nettype none
module ccd_capture
  import ccd_ctl_pkg::*;
#(
  parameter int DATA_W = 18
) (
  input  wire logic              clk_in,       // System clock
  input  wire logic              rst_n_in,     // Sync reset, active low
  input  wire logic [DATA_W-1:0] data_pins_in, // Result pins
  input  wire logic              dvalid_in,    // Data-valid strobe pin
  output logic      [DATA_W-1:0] result_out,   // Captured code
  output logic                   sample_out    // One-cycle capture pulse
);

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] data_m_q, data_s_q;
  logic              dv_m_q, dv_s_q, dv_old_q;
  logic [3:0]        wait_q;
  logic              armed_q;
  wire               dv_fell = dv_old_q & ~dv_s_q;
  wire               take    = armed_q & (wait_q == 4'h0);

  always_ff @(posedge clk_in) begin
    data_m_q <= data_pins_in;
    data_s_q <= data_m_q;
    dv_m_q   <= dvalid_in;
    dv_s_q   <= dv_m_q;
    dv_old_q <= dv_s_q;
  end

  // ---------------------------------------------------------------
  // Sample after the setup time past the strobe's falling edge
  // ---------------------------------------------------------------
  // Data pass the same two stages as the strobe, so the wait below is
  // measured at the pins as well.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      armed_q    <= 1'b0;
      wait_q     <= 4'h0;
      result_out <= '0;
      sample_out <= 1'b0;
    end else begin
      sample_out <= take;
      if (dv_fell) begin
        armed_q <= 1'b1;
        wait_q  <= 4'(DATA_SETUP_CYC - 1);
      end else if (take) begin
        armed_q <= 1'b0;
      end else if (armed_q) begin
        wait_q <= wait_q - 4'h1;
      end
      if (take) begin
        result_out <= data_s_q;
      end
    end
  end

endmodule
`default_nettype wire

// ==== hdl/ccd_apb_regs.sv ====
// APB slave holding the controller's own control and status registers.
// Assumes an APB master on clk_in; the slave answers with no wait state.
`default_nettype none
module ccd_apb_regs
  import ccd_ctl_pkg::*;
#(
  parameter int DATA_W = 18
) (
  input  wire logic              clk_in,       // System clock
  input  wire logic              rst_n_in,     // Sync reset, active low
  input  wire logic              psel_in,      // APB select
  input  wire logic              penable_in,   // APB enable
  input  wire logic              pwrite_in,    // APB direction
  input  wire logic [ADDR_W-1:0] paddr_in,     // APB byte address
  input  wire logic [31:0]       pwdata_in,    // APB write data
  output logic      [31:0]       prdata_out,   // APB read data
  output logic                   pready_out,   // APB ready
  output logic                   pslverr_out,  // APB error, unmapped
  output logic                   run_en_out,   // Run conversions
  output logic      [1:0]        rate_out,     // Requested rate
  input  wire logic              busy_in,      // Sequencer active
  input  wire logic [DATA_W-1:0] result_in,    // Kept result
  input  wire logic              result_set_in, // New kept result
  input  wire logic              discard_in    // Result discarded
);

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a == REG_CTRL) || (a == REG_STATUS) ||
             (a == REG_DATA) || (a == REG_COUNT);
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [2:0]        ctrl_q;
  logic [DATA_W-1:0] data_q;
  logic              valid_q, ovr_q;
  logic [15:0]       kept_cnt_q, disc_cnt_q;
  logic [31:0]       rd_mux;

  wire setup  = psel_in & ~penable_in;
  wire access = psel_in & penable_in;
  wire wr     = access & pwrite_in;
  wire rd_dat = access & ~pwrite_in & (paddr_in == REG_DATA);
  wire wr_ctl = wr & (paddr_in == REG_CTRL);
  wire wr_st  = wr & (paddr_in == REG_STATUS);

  assign pready_out  = access;
  assign pslverr_out = access & ~mapped(paddr_in);
  assign run_en_out  = ctrl_q[CTRL_EN_BIT];
  assign rate_out    = ctrl_q[CTRL_RATE_LSB +: 2];

  always_comb begin
    rd_mux = 32'h0;
    case (paddr_in)
      REG_CTRL:   rd_mux = {29'h0, ctrl_q};
      REG_STATUS: rd_mux = {29'h0, ovr_q, valid_q, busy_in};
      REG_DATA:   rd_mux = {{(32 - DATA_W){1'b0}}, data_q};
      REG_COUNT:  rd_mux = {disc_cnt_q, kept_cnt_q};
      default:    rd_mux = 32'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // A new result arriving in the cycle of a clear keeps its flag set.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_q     <= CTRL_RESET;
      data_q     <= '0;
      valid_q    <= 1'b0;
      ovr_q      <= 1'b0;
      kept_cnt_q <= 16'h0;
      disc_cnt_q <= 16'h0;
      prdata_out <= 32'h0;
    end else begin
      if (setup) prdata_out <= rd_mux;
      if (wr_ctl) ctrl_q <= pwdata_in[2:0];
      if (result_set_in) begin
        data_q     <= result_in;
        kept_cnt_q <= kept_cnt_q + 16'h1;
      end
      if (discard_in) disc_cnt_q <= disc_cnt_q + 16'h1;
      valid_q <= result_set_in | (valid_q & ~rd_dat);
      ovr_q   <= (result_set_in & valid_q & ~rd_dat) |
                 (ovr_q & ~(wr_st & pwdata_in[STAT_OVR_BIT]));
    end
  end

endmodule
`default_nettype wire

// ==== verif/ccd_conv_model.sv ====
// Behavioural converter with its sampler, answering each trigger once.
// Assumes the difference (reference minus pixel) arrives in code steps.
`default_nettype none
module ccd_conv_model (
  input  wire logic               ref_hold_in,   // Reference hold pin
  input  wire logic               start_conv_in, // Conversion trigger
  input  wire logic signed [31:0] diff_in,       // Ref minus pixel
  input  wire logic               slow_in,       // Answer late
  output logic             [17:0] data_out,      // Result pins
  output logic                    dvalid_out     // Data-valid strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [31:0] held;
  initial begin
    data_out = 18'h15555;
    dvalid_out = 1'b0;
  end
  // Stale pins show a changed pattern until the new result is valid
  always @(posedge start_conv_in) begin
    // A trigger without a held reference converts garbage (full scale)
    held = ref_hold_in ? diff_in : 32'sh7fffffff;
    data_out = ~data_out;
    // Kept off the system clock's edges, as a free-running pin would be
    #(slow_in ? 503 : 203);
    dvalid_out = 1'b1;
    #40 dvalid_out = 1'b0;
    #20;
    if (held <= 0)
      data_out = 18'h0;
    else if (held > 32'sh3ffff)
      data_out = 18'h3ffff;
    else
      data_out = held[17:0];
  end
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the CCD sequencing controller.
// Assumes the converter model stands on the pin side.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ccd_ctl_pkg::*;
  logic clk_in, rst_n_in, psel, pen, pwr, slow, pready, perr, er;
  logic hold, strt, b0, b1, dv;
  logic [7:0] paddr;
  logic [31:0] pwd, prd, rd, c;
  logic [17:0] pins;
  logic [3:0] pv;
  logic signed [31:0] diff;
  int err_total, total_checks, cyc, rises, lr, hr, hf;
  bit have;
  int per[4] = '{CONV_PERIOD_CYC_0, CONV_PERIOD_CYC_1,
                 CONV_PERIOD_CYC_2, CONV_PERIOD_CYC_3};
  int aq[4] = '{REF_ACQ_CYC_0, REF_ACQ_CYC_1, REF_ACQ_CYC_2, REF_ACQ_CYC_3};
  int st[4] = '{PIX_SETTLE_CYC_0, PIX_SETTLE_CYC_1,
                PIX_SETTLE_CYC_2, PIX_SETTLE_CYC_3};

  // STALE_LIM cut down so an idle gap fits in a short run
  ccd_seq_ctl #(.STALE_LIM(300)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
    .pwdata_in(pwd), .prdata_out(prd), .pready_out(pready),
    .pslverr_out(perr), .ref_hold_out(hold), .start_conv_out(strt),
    .bw_select_bit0_out(b0), .bw_select_bit1_out(b1),
    .data_pins_in(pins), .dvalid_in(dv));
  ccd_conv_model conv (.ref_hold_in(hold), .start_conv_in(strt),
    .diff_in(diff), .slow_in(slow), .data_out(pins), .dvalid_out(dv));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic final_report();
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk_in);
    pen <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wait_cnt(input logic [31:0] want);
    for (int i = 0; i < 200 && rd !== want; i++)
      apb(1'b0, REG_COUNT, 32'h0);
    chk(rd === want, "result count");
  endtask

  // Pin timing watcher; a trigger spacing is judged within one rate
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    pv <= {hold, strt, b1, b0};
    if (!rst_n_in)
      have <= 1'b0;
    else begin
      if (strt && !pv[2]) begin
        rises <= rises + 1;
        lr <= cyc;
        have <= 1'b1;
        if (have) chk(cyc - lr >= per[{b1, b0}], "spacing");
        chk(hold && cyc - hr >= st[{b1, b0}], "settle");
      end
      if (hold && !pv[3]) begin
        hr <= cyc;
        chk(cyc - hf >= aq[{b1, b0}], "acquire");
      end
      if (!hold && pv[3]) begin
        hf <= cyc;
        chk(lr > hr, "hold released early");
      end
      if (have && {hold, strt, b1, b0} != pv && cyc - lr inside {[14:32]})
        chk(1'b0, "pin toggled in window");
      if ({b1, b0} != pv[1:0]) begin
        chk(!pv[3] && !pv[2], "bw moved in sequence");
        have <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk({hold, strt, b1, b0} === 4'h0, "pins after reset");
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd === 32'h0 && er === 1'b0, "ctrl reset");
    apb(1'b0, 8'h10, 32'h0);
    chk(er === 1'b1 && rd === 32'h0, "unmapped read");
  endtask
  task automatic t_rates();
    int t;
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, REG_CTRL, {29'h0, r[1:0], 1'b1});
      t = rises + 3;
      for (int i = 0; i < 3000 && rises < t; i++)
        @(posedge clk_in);
      chk(rises >= t, "trigger count");
      chk({b1, b0} === r[1:0], "bw pins");
    end
  endtask
  task automatic t_codes();
    logic signed [31:0] d[5] = '{-5, 0, 1, 131072, 300000};
    logic [17:0] e[5] = '{18'h0, 18'h0, 18'h1, 18'h20000, 18'h3ffff};
    apb(1'b1, REG_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      diff <= d[i];
      slow <= i[0];
      apb(1'b0, REG_COUNT, 32'h0);
      wait_cnt(rd + 32'h2);
      apb(1'b0, REG_DATA, 32'h0);
      chk(rd[17:0] === e[i], "result code");
    end
  endtask
  task automatic t_stale();
    apb(1'b1, REG_CTRL, 32'h0);
    repeat (400) @(posedge clk_in);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:0] === 3'b110, "idle status");
    apb(1'b1, REG_STATUS, 32'h4);
    apb(1'b0, REG_DATA, 32'h0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd === 32'h0, "status cleared");
    apb(1'b0, REG_COUNT, 32'h0);
    c = rd;
    apb(1'b1, REG_CTRL, 32'h1);
    wait_cnt(c + 32'h10000);
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    #300000;
    err_total++;
    final_report();
  end
  initial begin
    {rst_n_in, psel, pen, pwr, slow} = 5'h0;
    paddr = 8'h0;
    pwd = 32'h0;
    diff = 32'sh100;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_rates();
    t_codes();
    t_stale();
    final_report();
  end
endmodule
`default_nettype wire
